//--- dv/conn_peer.sv
/*
 Model of the parallel peripheral on the board connector.
 Assumes pull-ups on every connector line and the glue's active-low enables.
*/
`timescale 1ns/1ps
module conn_peer (
    // Board side
    input  wire ppio_pkg::port_bytes_t pin_out,
    input  wire ppio_pkg::port_bytes_t pin_oe_n,
    // Peer drive, high enable drives the line
    input  wire ppio_pkg::port_bytes_t drv_val,
    input  wire ppio_pkg::port_bytes_t drv_en,
    // Resolved line levels
    output ppio_pkg::port_bytes_t      pin_in
);
    // ------------------------------------------------------------
    // Line resolution
    // ------------------------------------------------------------
    // Both driving gives unknown, so contention never passes a check
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            case ({~pin_oe_n[i], drv_en[i]})
                2'b10: pin_in[i] = pin_out[i];
                2'b01: pin_in[i] = drv_val[i];
                2'b00: pin_in[i] = 1'b1;
                default: pin_in[i] = 1'bx;
            endcase
        end
    end
endmodule // conn_peer

//--- dv/tb_board_parallel_port_glue.sv
/*
 Self-checking bench for the parallel port glue, APB master and peer.
 Assumes pready answers within a few cycles and single-clock operation.
*/
`timescale 1ns/1ps
module tb_board_parallel_port_glue;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                  pclk = 1'b0;
    logic                  presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]            paddr, cfg_strap_n, v, x;
    logic [31:0]           pwdata, prdata, rv;
    logic                  ev, dir_strap_fitted, ext_irq, ext_led;
    ppio_pkg::port_bytes_t pin_in, pin_out, pin_oe_n, drv_val, drv_en;
    ppio_pkg::site_io_t    site;
    logic                  xcvr_dir_in, xcvr_en_n, led_on, irq;
    logic                  bus_lock_force_n, nonvolatile_store_enable_n;
    logic                  parallel_port_irq, logic_site_irq;
    logic                  logic_site_dma_req_n;
    logic [3:0]            site2_view_b;
    logic [1:0]            p;
    int                    miscompares = 0;
    int                    n_checks = 0;

    always #12.5 pclk = ~pclk;

    board_parallel_port_glue dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .xcvr_dir_in(xcvr_dir_in),
        .xcvr_en_n(xcvr_en_n), .dir_strap_fitted(dir_strap_fitted),
        .cfg_strap_n(cfg_strap_n), .ext_irq(ext_irq), .ext_led(ext_led),
        .site(site), .site2_view_b(site2_view_b),
        .bus_lock_force_n(bus_lock_force_n),
        .nonvolatile_store_enable_n(nonvolatile_store_enable_n),
        .parallel_port_irq(parallel_port_irq),
        .logic_site_irq(logic_site_irq),
        .logic_site_dma_req_n(logic_site_dma_req_n),
        .led_on(led_on), .irq(irq));

    conn_peer peer (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .drv_val(drv_val), .drv_en(drv_en), .pin_in(pin_in));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 64) begin
            n++;
            @(posedge pclk);
        end
        chk(n < 64, 1'b1, "pready wait");
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    // Transceiver levels {dir_in, en_n} for strap or port C source
    function automatic logic [1:0] exp_xcvr(int s, logic k);
        return (s == 0) ? {dir_strap_fitted, 1'b0} : {~k, k};
    endfunction

    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        drv_val = '0;
        drv_en = '0;
        site = '0;
        cfg_strap_n = 8'hFF;
        {dir_strap_fitted, ext_irq, ext_led} = 3'h4;
        void'($urandom(32'h833ccf81));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(pin_oe_n, 24'hFFFFFF, "oe reset");
        chk(led_on, 1'b1, "led reset");
        chk(xcvr_en_n, 1'b0, "en tie");
        chk(xcvr_dir_in, 1'b1, "strap in");
        chk(nonvolatile_store_enable_n, 1'b1, "nv reset");
        chk(irq, 1'b0, "irq reset");
        for (int i = 3; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), '0);
            chk(rv, '0, "reg reset");
        end
        @(posedge pclk);
        dir_strap_fitted <= 1'b0;
        @(negedge pclk);
        chk(xcvr_dir_in, 1'b0, "strap out");
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        apb(1'b0, 8'h20, '0);
        chk({ev, rv[30:0]}, '1 << 31, "unmapped");
        apb(1'b0, ppio_pkg::OFF_MODE, '0);
        chk({ev, rv[30:0]}, '0, "mode kept");
        $display("test map done");
        apb(1'b1, ppio_pkg::OFF_MODE, 32'h1 << ppio_pkg::MODE_A_OUT);
        repeat (4) begin
            v = 8'($urandom);
            apb(1'b1, ppio_pkg::OFF_PORT_A, {24'h0, v});
            chk({pin_oe_n.a, pin_out.a}, {8'h00, v}, "A out");
        end
        dir_strap_fitted <= 1'b1;
        apb(1'b1, ppio_pkg::OFF_MODE, '0);
        @(posedge pclk);
        x = 8'($urandom);
        drv_val.a <= x;
        drv_en.a <= 8'hFF;
        apb(1'b0, ppio_pkg::OFF_PORT_A, '0);
        chk(rv, {24'h0, x}, "A in");
        drv_en.a <= 8'h00;
        dir_strap_fitted <= 1'b0;
        apb(1'b1, ppio_pkg::OFF_MODE, 32'h1 << ppio_pkg::MODE_A_BIDI);
        chk(pin_oe_n.a, 8'h00, "A bidi");
        $display("test port_a done");
        x = 8'($urandom);
        v = 8'($urandom) | 8'h69;
        drv_val.b <= x;
        drv_en.b <= 8'hFF;
        cfg_strap_n <= v;
        apb(1'b0, ppio_pkg::OFF_PORT_B, '0);
        chk(rv, {24'h0, x & v}, "B straps");
        chk(site2_view_b, {x[7] & v[7], x[6:5], x[1] & v[1]}, "view");
        drv_en.b <= 8'h00;
        cfg_strap_n <= 8'hFF;
        apb(1'b1, ppio_pkg::OFF_MODE, 32'h1 << ppio_pkg::MODE_B_OUT);
        v = 8'($urandom);
        apb(1'b1, ppio_pkg::OFF_PORT_B, {24'h0, v});
        chk({pin_oe_n.b, pin_out.b}, {8'h00, v}, "B out");
        apb(1'b1, ppio_pkg::OFF_MODE, '0);
        site.b_ovr <= 8'($urandom);
        drv_en.b <= 8'hFF;
        apb(1'b1, ppio_pkg::OFF_ROUTE, 32'hA0);
        apb(1'b0, ppio_pkg::OFF_PORT_B, '0);
        chk(rv[7:0] & 8'h82, site.b_ovr & 8'h82, "B reroute");
        $display("test port_b done");
        apb(1'b1, ppio_pkg::OFF_MODE, 32'hC);
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 2; k++) begin
                site.dir <= k[0];
                site.en <= k[0];
                apb(1'b1, ppio_pkg::OFF_ROUTE, 32'(s | (s << 2)));
                apb(1'b1, ppio_pkg::OFF_PORT_C, k[0] ? 32'h90 : 32'h0);
                if (s < 2) begin
                    chk({xcvr_dir_in, xcvr_en_n}, exp_xcvr(s, k[0]), "xc");
                end else if (k == 0) begin
                    p = {xcvr_dir_in, xcvr_en_n};
                end else begin
                    chk({xcvr_dir_in, xcvr_en_n}, {~p[1], ~p[0]}, "xc site");
                end
            end
        end
        $display("test xcvr done");
        apb(1'b1, ppio_pkg::OFF_ROUTE, 32'h1 << ppio_pkg::RT_LOCK);
        repeat (4) begin
            v = 8'($urandom);
            apb(1'b1, ppio_pkg::OFF_PORT_C, {24'h0, v});
            chk(bus_lock_force_n, v[5], "lock C");
            chk(nonvolatile_store_enable_n, v[6], "nv C");
            chk(led_on, {~v[4]}, "led C");
        end
        drv_val.b[7] <= ~v[5];
        apb(1'b1, ppio_pkg::OFF_ROUTE, 32'h1 << ppio_pkg::RT_LED_EXT);
        chk(bus_lock_force_n, {~v[5]}, "lock B");
        ext_led <= 1'b1;
        apb(1'b1, ppio_pkg::OFF_MODE, 32'h1 << ppio_pkg::MODE_C_LOUT);
        chk(led_on, 1'b1, "led ext");
        chk(nonvolatile_store_enable_n, 1'b1, "nv gated");
        $display("test board done");
        v = 8'($urandom);
        apb(1'b1, ppio_pkg::OFF_PORT_C, {24'h0, v});
        chk({pin_oe_n.c[3:0], pin_out.c[3:0]}, {v[3:0], 4'h0}, "oc");
        apb(1'b0, ppio_pkg::OFF_PORT_C, '0);
        chk(rv[3:0], v[3:0], "oc read");
        site.oc_ctl <= 8'($urandom);
        apb(1'b1, ppio_pkg::OFF_ROUTE, 32'h1 << ppio_pkg::RT_OC_SITE);
        chk(pin_oe_n.c[3:0], site.oc_ctl[3:0], "oc site");
        $display("test port_c done");
        apb(1'b1, ppio_pkg::OFF_IRQ_MASK, 32'h3);
        apb(1'b1, ppio_pkg::OFF_ROUTE, 32'h1 << ppio_pkg::RT_PPI_EXT);
        ext_irq <= 1'b1;
        apb(1'b0, ppio_pkg::OFF_IRQ_STAT, '0);
        chk({parallel_port_irq, irq}, 2'b11, "ppi ext");
        chk(rv, 32'h1, "ppi stat");
        apb(1'b1, ppio_pkg::OFF_IRQ_MASK, 32'h2);
        chk(irq, 1'b0, "masked");
        apb(1'b1, ppio_pkg::OFF_IRQ_STAT, 32'h1);
        apb(1'b0, ppio_pkg::OFF_IRQ_STAT, '0);
        chk(rv, '0, "w1c");
        site.irq <= 1'b1;
        site.drq_n <= 1'b1;
        apb(1'b0, ppio_pkg::OFF_IRQ_STAT, '0);
        chk({logic_site_irq, irq}, 2'b11, "site irq");
        chk(rv, 32'h2, "site stat");
        chk(logic_site_dma_req_n, 1'b1, "drq");
        site.drq_n <= 1'b0;
        @(posedge pclk);
        chk(logic_site_dma_req_n, 1'b0, "drq low");
        apb(1'b1, ppio_pkg::OFF_ROUTE, '0);
        apb(1'b1, ppio_pkg::OFF_PORT_C, 32'h08);
        chk(parallel_port_irq, 1'b1, "ppi C3");
        $display("test irq done");
        report_and_stop();
    end
endmodule // tb_board_parallel_port_glue

//--- logic/board_parallel_port_glue.sv
/*
 Board parallel port glue: three 8-bit ports, transceiver control,
 board control lines, two interrupt sources, DMA request and LED.
 Assumes an APB master on pclk, all pins synchronous to pclk.
*/
`timescale 1ns/1ps
module board_parallel_port_glue (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Connector port pins (oe low drives)
    input  wire ppio_pkg::port_bytes_t pin_in,
    output ppio_pkg::port_bytes_t     pin_out,
    output ppio_pkg::port_bytes_t     pin_oe_n,
    output logic                      xcvr_dir_in,
    output logic                      xcvr_en_n,
    // Board straps and external signals
    input  wire logic                 dir_strap_fitted,
    input  wire logic [7:0]           cfg_strap_n,
    input  wire logic                 ext_irq,
    input  wire logic                 ext_led,
    // Programmable logic sites
    input  wire ppio_pkg::site_io_t   site,
    output logic [3:0]                site2_view_b,
    // Board control outputs
    output logic                      bus_lock_force_n,
    output logic                      nonvolatile_store_enable_n,
    output logic                      parallel_port_irq,
    output logic                      logic_site_irq,
    output logic                      logic_site_dma_req_n,
    output logic                      led_on,
    output logic                      irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ppio_pkg::state_t s_q;
    ppio_pkg::state_t s_d;

    logic                      wr_en;
    logic                      rd_en;
    logic                      addr_ok;
    logic                      a_is_out;
    logic [7:0]                b_seen;
    logic [7:0]                c_seen;
    logic [ppio_pkg::IRQ_W-1:0] src_now;
    logic [ppio_pkg::IRQ_W-1:0] rise;

    // Offset decode for pslverr only, on reads and writes alike
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ppio_pkg::OFF_PORT_A)   ||
                 (a == ppio_pkg::OFF_PORT_B)   ||
                 (a == ppio_pkg::OFF_PORT_C)   ||
                 (a == ppio_pkg::OFF_MODE)     ||
                 (a == ppio_pkg::OFF_ROUTE)    ||
                 (a == ppio_pkg::OFF_IRQ_STAT) ||
                 (a == ppio_pkg::OFF_IRQ_MASK) ||
                 (a == ppio_pkg::OFF_PIN_STATE);
    endfunction

    // Three-way source select
    function automatic logic pick3(input logic [1:0] sel,
                                   input logic       v0,
                                   input logic       v1,
                                   input logic       v2);
        unique case (sel)
            2'h1:    pick3 = v1;
            2'h2:    pick3 = v2;
            default: pick3 = v0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    assign addr_ok = mapped(paddr);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = s_q.prdata;

    // ------------------------------------------------------------
    // Port A transceiver
    // ------------------------------------------------------------
    // Strap fitted drives xcvr_dir_in high: input mode
    assign xcvr_dir_in = pick3(s_q.route[ppio_pkg::RT_DIR_LSB +: 2],
                               dir_strap_fitted,
                               !s_q.latch.c[ppio_pkg::PC_DIR],
                               site.dir);
    assign xcvr_en_n = pick3(s_q.route[ppio_pkg::RT_EN_LSB +: 2],
                             1'b0,
                             s_q.latch.c[ppio_pkg::PC_EN],
                             site.en);
    // Bidirectional mode lets the transceiver pick; else mode bit gated by transceiver direction
    assign a_is_out = s_q.mode[ppio_pkg::MODE_A_BIDI] ?
                      !xcvr_dir_in :
                      s_q.mode[ppio_pkg::MODE_A_OUT] && !xcvr_dir_in;
    assign pin_out.a  = s_q.latch.a;
    assign pin_oe_n.a = {8{!(a_is_out && !xcvr_en_n)}};

    // ------------------------------------------------------------
    // Port B with rerouted bits
    // ------------------------------------------------------------
    always_comb begin
        b_seen    = pin_in.b & cfg_strap_n;
        b_seen[1] = pick3(s_q.route[ppio_pkg::RT_PB1_LSB +: 2],
                          pin_in.b[1] & cfg_strap_n[1],
                          s_q.latch.c[0],
                          site.b_ovr[1]);
        b_seen[7] = pick3(s_q.route[ppio_pkg::RT_PB7_LSB +: 2],
                          pin_in.b[7] & cfg_strap_n[7],
                          s_q.latch.c[1],
                          site.b_ovr[7]);
    end
    // Weak output: the connector load must respect the low drive
    assign pin_out.b  = s_q.latch.b;
    assign pin_oe_n.b = {8{!s_q.mode[ppio_pkg::MODE_B_OUT]}};
    assign site2_view_b = {b_seen[7], b_seen[6], b_seen[5],
                           b_seen[1]};

    // ------------------------------------------------------------
    // Port C: open-collector low nibble, board high nibble
    // ------------------------------------------------------------
    always_comb begin
        c_seen = s_q.latch.c;
        c_seen[3:0] = pin_in.c[3:0];
    end
    // Open-collector: only a low is driven, a high floats
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_oc
            logic lvl;
            assign lvl = s_q.route[ppio_pkg::RT_OC_SITE] ?
                         site.oc_ctl[g] : s_q.latch.c[g];
            assign pin_out.c[g]  = 1'b0;
            assign pin_oe_n.c[g] =
                !(s_q.mode[ppio_pkg::MODE_C_LOUT] && !lvl);
        end
        for (g = 4; g < 8; g++) begin : g_hi
            assign pin_out.c[g]  = 1'b0;
            assign pin_oe_n.c[g] = 1'b1;
        end
    endgenerate

    // ------------------------------------------------------------
    // Board control lines
    // ------------------------------------------------------------
    assign bus_lock_force_n = s_q.route[ppio_pkg::RT_LOCK] ?
                              s_q.latch.c[ppio_pkg::PC_LOCK] :
                              b_seen[7];
    // Store stays disabled until software claims the high nibble
    assign nonvolatile_store_enable_n =
        s_q.latch.c[ppio_pkg::PC_NONVOLATILE_STORE_ENABLE_N] ||
        !s_q.mode[ppio_pkg::MODE_C_HOUT];
    // LED lit while the control bit is low, so lit from reset
    assign led_on = s_q.route[ppio_pkg::RT_LED_EXT] ?
                    ext_led : !s_q.latch.c[ppio_pkg::PC_EN];
    assign parallel_port_irq = s_q.route[ppio_pkg::RT_PPI_EXT] ?
                               ext_irq :
                               s_q.latch.c[ppio_pkg::PC_PPI];
    assign logic_site_irq       = site.irq;
    assign logic_site_dma_req_n = site.drq_n;

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    assign src_now = {logic_site_irq, parallel_port_irq};
    assign rise    = src_now & ~s_q.src_prev;
    assign irq     = |(s_q.stat & s_q.mask);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.src_prev = src_now;
        if (wr_en) begin
            unique case (paddr)
                ppio_pkg::OFF_PORT_A: s_d.latch.a = pwdata[7:0];
                ppio_pkg::OFF_PORT_B: s_d.latch.b = pwdata[7:0];
                ppio_pkg::OFF_PORT_C: s_d.latch.c = pwdata[7:0];
                ppio_pkg::OFF_MODE: begin
                    // A mode word clears every latch
                    s_d.mode  = pwdata[ppio_pkg::MODE_W-1:0];
                    s_d.latch = '0;
                end
                ppio_pkg::OFF_ROUTE:
                    s_d.route = pwdata[ppio_pkg::RT_W-1:0];
                ppio_pkg::OFF_IRQ_STAT:
                    s_d.stat = s_q.stat & ~pwdata[ppio_pkg::IRQ_W-1:0];
                ppio_pkg::OFF_IRQ_MASK:
                    s_d.mask = pwdata[ppio_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        s_d.stat = s_d.stat | rise;
        if (rd_en) begin
            unique case (paddr)
                ppio_pkg::OFF_PORT_A:
                    s_d.prdata = {24'h0, a_is_out ? s_q.latch.a
                                                  : pin_in.a};
                ppio_pkg::OFF_PORT_B:
                    s_d.prdata = {24'h0, b_seen};
                ppio_pkg::OFF_PORT_C:
                    s_d.prdata = {24'h0, c_seen};
                ppio_pkg::OFF_MODE:
                    s_d.prdata = {27'h0, s_q.mode};
                ppio_pkg::OFF_ROUTE:
                    s_d.prdata = {20'h0, s_q.route};
                ppio_pkg::OFF_IRQ_STAT:
                    s_d.prdata = {30'h0, s_q.stat};
                ppio_pkg::OFF_IRQ_MASK:
                    s_d.prdata = {30'h0, s_q.mask};
                ppio_pkg::OFF_PIN_STATE:
                    s_d.prdata = {26'h0, xcvr_dir_in, xcvr_en_n,
                                  bus_lock_force_n, led_on,
                                  logic_site_dma_req_n, irq};
                default:
                    s_d.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_inputs: assert property (
        $rose(presetn) |-> &pin_oe_n.a && &pin_oe_n.b)
        else $error("ports not input after reset");
    chk_mode_clears: assert property (
        wr_en && paddr == ppio_pkg::OFF_MODE |=> s_q.latch == '0)
        else $error("mode word did not clear latches");
    chk_strap_dir: assert property (
        s_q.route[1:0] == ppio_pkg::SRC_STRAP && dir_strap_fitted
        |-> &pin_oe_n.a)
        else $error("strap fitted but port A drives");
    chk_dir_portc: assert property (
        s_q.route[1:0] == ppio_pkg::SRC_PORTC
        |-> xcvr_dir_in == !s_q.latch.c[7])
        else $error("direction not from port C bit 7");
    chk_en_ground: assert property (
        s_q.route[3:2] == ppio_pkg::SRC_STRAP |-> !xcvr_en_n)
        else $error("enable not tied on");
    chk_hi_nibble: assert property (
        pin_oe_n.c[7:4] == 4'hF && pin_out.c == 8'h00)
        else $error("port C drives a high or upper bit");
    chk_lock_sel: assert property (
        s_q.route[8] |-> bus_lock_force_n == s_q.latch.c[5])
        else $error("bus lock not from port C bit 5");
    chk_irq_sticky: assert property (
        $rose(parallel_port_irq) ##1 !(wr_en && paddr ==
        ppio_pkg::OFF_IRQ_STAT) |=> s_q.stat[0])
        else $error("port interrupt not latched");
    chk_site_pass: assert property (
        logic_site_dma_req_n == site.drq_n &&
        logic_site_irq == site.irq)
        else $error("site outputs not passed through");
    chk_led_reset: assert property (
        $rose(presetn) |-> led_on)
        else $error("LED dark after reset");
    chk_irq_out: assert property (
        $rose(logic_site_irq) && s_q.mask[1] &&
        !(wr_en && paddr == ppio_pkg::OFF_IRQ_MASK) |=> irq)
        else $error("site event did not raise interrupt");

    chk_a_drives: assert property (
        s_q.mode[0] && !xcvr_dir_in && !xcvr_en_n
        |-> pin_oe_n.a == 8'h00)
        else $error("port A idle in output mode");

    chk_dir_site: assert property (
        s_q.route[1:0] == ppio_pkg::SRC_SITE
        |-> xcvr_dir_in == site.dir)
        else $error("direction not from site");

    chk_en_portc: assert property (
        s_q.route[3:2] == ppio_pkg::SRC_PORTC
        |-> xcvr_en_n == s_q.latch.c[4])
        else $error("enable not from port C bit 4");

    chk_b_input: assert property (
        !s_q.mode[1]
        |-> pin_oe_n.b == 8'hFF)
        else $error("port B drives in input mode");

    chk_b_output: assert property (
        s_q.mode[1]
        |-> pin_oe_n.b == 8'h00)
        else $error("port B not driving");

    chk_b1_route: assert property (
        s_q.route[5:4] == ppio_pkg::PB_SITE
        |-> b_seen[1] == site.b_ovr[1])
        else $error("B1 not from site");

    chk_b_strap: assert property (
        !cfg_strap_n[4]
        |-> !b_seen[4])
        else $error("strapped B4 reads high");

    chk_site_view: assert property (
        site2_view_b[2:1]
        == (pin_in.b[6:5] & cfg_strap_n[6:5]))
        else $error("site view of B5 B6 wrong");

    chk_oc_off: assert property (
        !s_q.mode[2]
        |-> pin_oe_n.c[3:0] == 4'hF)
        else $error("port C low nibble drives");

    chk_oc_site: assert property (
        s_q.route[11] && s_q.mode[2]
        |-> pin_oe_n.c[3:0] == site.oc_ctl[3:0])
        else $error("drivers not site controlled");

    chk_nv_gate: assert property (
        !s_q.mode[3]
        |-> nonvolatile_store_enable_n)
        else $error("store enabled without control");

    chk_led_ext: assert property (
        s_q.route[10]
        |-> led_on == ext_led)
        else $error("LED not from external");

    chk_ppi_ext: assert property (
        s_q.route[9]
        |-> parallel_port_irq == ext_irq)
        else $error("port interrupt not external");

    chk_lock_b7: assert property (
        !s_q.route[8]
        |-> bus_lock_force_n == b_seen[7])
        else $error("bus lock not from B7");

    cov_a_out:   cover property (!pin_oe_n.a[0]);
    cov_b_out:   cover property (!pin_oe_n.b[0]);
    cov_irq:     cover property ($rose(irq));
    cov_oc_site: cover property (s_q.route[11] && !pin_oe_n.c[0]);
    cov_bidi:    cover property (s_q.mode[4] && !pin_oe_n.a[0]);

endmodule // board_parallel_port_glue

//--- logic/ppio_pkg.sv
/*
 Shared constants and carriers for the board parallel port glue.
 Assumes a 32-bit APB master and a single 40 MHz clock.
*/
package ppio_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PORT_A    = 8'h00;
    localparam logic [7:0] OFF_PORT_B    = 8'h04;
    localparam logic [7:0] OFF_PORT_C    = 8'h08;
    localparam logic [7:0] OFF_MODE      = 8'h0C;
    localparam logic [7:0] OFF_ROUTE     = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;
    localparam logic [7:0] OFF_PIN_STATE = 8'h1C;

    // ------------------------------------------------------------
    // Mode word fields
    // ------------------------------------------------------------
    localparam int MODE_A_OUT  = 0;
    localparam int MODE_B_OUT  = 1;
    localparam int MODE_C_LOUT = 2;
    localparam int MODE_C_HOUT = 3;
    localparam int MODE_A_BIDI = 4;
    localparam int MODE_W      = 5;

    // Route word fields
    localparam int RT_DIR_LSB  = 0;
    localparam int RT_EN_LSB   = 2;
    localparam int RT_PB1_LSB  = 4;
    localparam int RT_PB7_LSB  = 6;
    localparam int RT_LOCK     = 8;
    localparam int RT_PPI_EXT  = 9;
    localparam int RT_LED_EXT  = 10;
    localparam int RT_OC_SITE  = 11;
    localparam int RT_W        = 12;

    // Source selects for port A direction and enable
    localparam logic [1:0] SRC_STRAP = 2'h0;
    localparam logic [1:0] SRC_PORTC = 2'h1;
    localparam logic [1:0] SRC_SITE  = 2'h2;

    // Port B bit 1 / 7 source selects
    localparam logic [1:0] PB_CONN  = 2'h0;
    localparam logic [1:0] PB_PORTC = 2'h1;
    localparam logic [1:0] PB_SITE  = 2'h2;

    // Port C bit positions with board functions
    localparam int PC_NONVOLATILE_STORE_ENABLE_N = 6;
    localparam int PC_LOCK = 5;
    localparam int PC_EN   = 4;
    localparam int PC_DIR  = 7;
    localparam int PC_PPI  = 3;

    // Interrupt status bits
    localparam int IRQ_PPI  = 0;
    localparam int IRQ_SITE = 1;
    localparam int IRQ_W    = 2;

    // Reset values
    localparam logic [7:0]        RST_PORT  = 8'h00;
    localparam logic [MODE_W-1:0] RST_MODE  = 5'h00;
    localparam logic [RT_W-1:0]   RST_ROUTE = 12'h000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } port_bytes_t;

    typedef struct packed {
        logic [7:0] b_ovr;
        logic [7:0] oc_ctl;
        logic       dir;
        logic       en;
        logic       irq;
        logic       drq_n;
    } site_io_t;

    typedef struct packed {
        port_bytes_t         latch;
        logic [MODE_W-1:0]   mode;
        logic [RT_W-1:0]     route;
        logic [IRQ_W-1:0]    stat;
        logic [IRQ_W-1:0]    mask;
        logic [IRQ_W-1:0]    src_prev;
        logic [31:0]         prdata;
    } state_t;

endpackage : ppio_pkg
